// File: hw/decoder_power_status_clamp_regs.sv
// Purpose: Power, status, revision, timing-output and clamp registers
// Assumes: APB slave, inputs synchronous to MCLK_I
// Notes:   Zero wait states, read data registered in the setup cycle
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module decoder_power_status_clamp_regs
   import decoder_regs_pkg::*;
#(
   parameter logic [7:0] REVISION_ID = 8'ha7   // Arbitrary value
) (
   // Clock and reset
   input  wire logic              MCLK_I,
   input  wire logic              RESET_I,
   // APB slave
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [ADDR_W-1:0] PADDR_I,
   input  wire logic [31:0]       PWDATA_I,
   input  wire logic [3:0]        PSTRB_I,
   output logic      [31:0]       PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   // Device pins and core status
   input  wire logic              POWERDOWN_N_I,
   input  wire logic              ISO_I,
   input  wire logic              OE_I,
   input  wire status_in_s        STATUS_I,
   input  wire logic              CLAMP_START_I,
   // Power control
   output power_out_s             POWER_O,
   output logic                   PAD_DISABLE_O,
   output logic                   CLK27_STOP_O,
   // Timing and reset events
   output logic                   REACQUIRE_O,
   output logic                   CORE_RESET_O,
   output logic                   TIMING_DRV_EN_O,
   // Clamp control
   output logic                   FINE_CLAMP_ON_O,
   output logic                   FAST_CLAMP_ON_O,
   output logic                   CURRENT_SRC_EN_O,
   output logic                   VCLAMP_EN_O
);

   ////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [7:0]  power;
      logic [7:0]  analog;
      logic [7:0]  clamp;
      logic [7:0]  timing;
      logic        lost_lock;
      logic [31:0] rdata;
      logic        ready;
      logic        err;
   } bank_s;

   bank_s state_r;
   bank_s state_nxt;

   logic       setup_phase;
   logic       access_done;
   logic       wr_done;
   logic       rd_done;
   logic       wr_lane0;
   logic       mapped;
   logic [7:0] rd_byte;
   logic [7:0] status_byte;
   logic       lock_lost_now;
   logic       status_read;
   logic       soft_reset;
   logic       shutdown;

   ////////////////////////////////////////////////////////////////////
   // Bus phases

   assign setup_phase = PSEL_I && !PENABLE_I;
   assign access_done = PSEL_I && PENABLE_I && state_r.ready;
   assign wr_done     = access_done && PWRITE_I && !state_r.err;
   assign rd_done     = access_done && !PWRITE_I && !state_r.err;
   assign wr_lane0    = wr_done && PSTRB_I[0];

   ////////////////////////////////////////////////////////////////////
   // Status byte

   assign status_byte = {
      STATUS_I.color_kill,
      STATUS_I.white_peak,
      STATUS_I.adc_overflow,
      STATUS_I.adc_underflow,
      STATUS_I.field_50hz,
      STATUS_I.fsc_locked,
      state_r.lost_lock,
      STATUS_I.in_lock
   };

   assign lock_lost_now = !STATUS_I.in_lock;
   assign status_read   = rd_done && (PADDR_I == ADDR_STATUS);

   ////////////////////////////////////////////////////////////////////
   // Read decode

   always_comb begin
      mapped  = 1'b1;
      rd_byte = 8'h00;
      case (PADDR_I)
         ADDR_POWER: begin
            rd_byte = state_r.power;
         end
         ADDR_STATUS: begin
            rd_byte = status_byte;
         end
         ADDR_REVISION: begin
            rd_byte = REVISION_ID;
         end
         ADDR_ANALOG: begin
            rd_byte = state_r.analog;
         end
         ADDR_CLAMP: begin
            rd_byte = state_r.clamp & CLAMP_WMASK;
         end
         ADDR_TIMING: begin
            rd_byte = state_r.timing & TIMING_WMASK;
         end
         default: begin
            mapped  = 1'b0;
            rd_byte = 8'h00;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Next state

   assign soft_reset = state_r.power[PWR_RESET];

   always_comb begin
      state_nxt = state_r;

      // Bus handshake: answer taken in setup, released after access
      if (setup_phase) begin
         state_nxt.ready = 1'b1;
         state_nxt.err   = !mapped;
         state_nxt.rdata = {24'h000000, rd_byte};
      end else if (access_done) begin
         state_nxt.ready = 1'b0;
         state_nxt.err   = 1'b0;
      end

      // Self-clearing event bits
      state_nxt.power[PWR_REACQ] = 1'b0;
      state_nxt.power[PWR_RESET] = 1'b0;

      // Register writes
      if (wr_lane0) begin
         case (PADDR_I)
            ADDR_POWER: begin
               state_nxt.power = PWDATA_I[7:0];
            end
            ADDR_ANALOG: begin
               state_nxt.analog = (ANALOG_RST & ~ANALOG_WMASK)
                                | (PWDATA_I[7:0] & ANALOG_WMASK);
            end
            ADDR_CLAMP: begin
               state_nxt.clamp = PWDATA_I[7:0] & CLAMP_WMASK;
            end
            ADDR_TIMING: begin
               state_nxt.timing = PWDATA_I[7:0] & TIMING_WMASK;
            end
            default: begin
               state_nxt.power = state_nxt.power;
            end
         endcase
      end

      // Sticky lock loss: a new loss wins over the read clear
      state_nxt.lost_lock = lock_lost_now
                          || (state_r.lost_lock && !status_read);

      // Soft reset returns the bank to defaults
      if (soft_reset) begin
         state_nxt.power     = POWER_RST;
         state_nxt.analog    = ANALOG_RST;
         state_nxt.clamp     = CLAMP_RST;
         state_nxt.timing    = TIMING_RST;
         state_nxt.lost_lock = lock_lost_now;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         state_r.power     <= POWER_RST;
         state_r.analog    <= ANALOG_RST;
         state_r.clamp     <= CLAMP_RST;
         state_r.timing    <= TIMING_RST;
         state_r.lost_lock <= 1'b0;
         state_r.rdata     <= 32'h00000000;
         state_r.ready     <= 1'b0;
         state_r.err       <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB outputs

   assign PRDATA_O  = state_r.rdata;
   assign PREADY_O  = PSEL_I && PENABLE_I && state_r.ready;
   assign PSLVERR_O = PSEL_I && PENABLE_I && state_r.ready && state_r.err;

   ////////////////////////////////////////////////////////////////////
   // Power control

   assign shutdown = state_r.power[PWR_PRIO]
                   ? state_r.power[PWR_DOWN]
                   : !POWERDOWN_N_I;

   assign POWER_O.power_save_select =
      power_save_e'(state_r.power[PWR_SAVE_LO +: 2]);
   assign POWER_O.reference_power_save =
      state_r.power[PWR_REF_PS];
   assign POWER_O.clockgen_power_save =
      state_r.power[PWR_CG_PS];
   assign POWER_O.core_shutdown = shutdown;

   assign PAD_DISABLE_O = shutdown;
   assign CLK27_STOP_O  = shutdown;

   ////////////////////////////////////////////////////////////////////
   // Events

   assign REACQUIRE_O  = state_r.power[PWR_REACQ] || ISO_I;
   assign CORE_RESET_O = soft_reset;

   ////////////////////////////////////////////////////////////////////
   // Timing output drivers

   assign TIMING_DRV_EN_O = state_r.analog[ANA_FORCE]
                          || (OE_I && !state_r.timing[TIM_DISABLE]);

   ////////////////////////////////////////////////////////////////////
   // Clamp control

   assign CURRENT_SRC_EN_O = state_r.clamp[CLP_CUR_EN];
   assign VCLAMP_EN_O      = state_r.clamp[CLP_VOLT_EN];

   clamp_pulse_timer #(
      .CNT_W      (CLAMP_CNT_W)
   ) u_fine_clamp (
      .clk_i      (MCLK_I),
      .rst_i      (RESET_I),
      .start_i    (CLAMP_START_I),
      .enable_i   (state_r.clamp[CLP_CUR_EN]),
      .len_code_i (state_r.clamp[CLP_FINE_LO +: 2]),
      .on_o       (FINE_CLAMP_ON_O)
   );

   clamp_pulse_timer #(
      .CNT_W      (CLAMP_CNT_W)
   ) u_fast_clamp (
      .clk_i      (MCLK_I),
      .rst_i      (RESET_I),
      .start_i    (CLAMP_START_I),
      .enable_i   (state_r.clamp[CLP_CUR_EN]),
      .len_code_i (state_r.clamp[CLP_FAST_LO +: 2]),
      .on_o       (FAST_CLAMP_ON_O)
   );

endmodule // decoder_power_status_clamp_regs

// File: hw/decoder_regs_pkg.sv
// Purpose: Shared constants and carriers for the decoder control bank
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register indices times four give the byte address
package decoder_regs_pkg;

   ////////////////////////////////////////////////////////////////////
   // Register indices and byte addresses
   localparam logic [7:0]  IDX_POWER     = 8'h0f;
   localparam logic [7:0]  IDX_STATUS    = 8'h10;
   localparam logic [7:0]  IDX_REVISION  = 8'h11;
   localparam logic [7:0]  IDX_ANALOG    = 8'h13;
   localparam logic [7:0]  IDX_CLAMP     = 8'h14;
   localparam logic [7:0]  IDX_TIMING    = 8'h20;
   localparam int          ADDR_W        = 12;
   localparam logic [11:0] ADDR_POWER    = {2'h0, IDX_POWER, 2'h0};
   localparam logic [11:0] ADDR_STATUS   = {2'h0, IDX_STATUS, 2'h0};
   localparam logic [11:0] ADDR_REVISION = {2'h0, IDX_REVISION, 2'h0};
   localparam logic [11:0] ADDR_ANALOG   = {2'h0, IDX_ANALOG, 2'h0};
   localparam logic [11:0] ADDR_CLAMP    = {2'h0, IDX_CLAMP, 2'h0};
   localparam logic [11:0] ADDR_TIMING   = {2'h0, IDX_TIMING, 2'h0};

   ////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int PWR_SAVE_LO   = 0;
   localparam int PWR_PRIO      = 2;
   localparam int PWR_REF_PS    = 3;
   localparam int PWR_CG_PS     = 4;
   localparam int PWR_DOWN      = 5;
   localparam int PWR_REACQ     = 6;
   localparam int PWR_RESET     = 7;
   localparam int ANA_FORCE     = 1;
   localparam int CLP_FINE_LO   = 0;
   localparam int CLP_FAST_LO   = 2;
   localparam int CLP_CUR_EN    = 4;
   localparam int CLP_VOLT_EN   = 5;
   localparam int TIM_DISABLE   = 0;

   ////////////////////////////////////////////////////////////////////
   // Reset values and masks
   localparam logic [7:0] POWER_RST     = 8'h00;
   localparam logic [7:0] ANALOG_RST    = 8'h45;
   localparam logic [7:0] ANALOG_WMASK  = 8'h02;
   localparam logic [7:0] CLAMP_RST     = 8'h00;
   localparam logic [7:0] CLAMP_WMASK   = 8'h3f;
   localparam logic [7:0] TIMING_RST    = 8'h00;
   localparam logic [7:0] TIMING_WMASK  = 8'h01;

   ////////////////////////////////////////////////////////////////////
   // Clamp pulse timing: shortest pulse in clock cycles
   localparam int         CLAMP_CNT_W   = 8;
   localparam logic [7:0] CLAMP_BASE_CYC = 8'h10;

   ////////////////////////////////////////////////////////////////////
   // Carriers
   typedef enum logic [1:0] {
      SAVE_FULL, SAVE_COMPOSITE, SAVE_DIGITAL, SAVE_POWER
   } power_save_e;

   typedef struct packed {
      logic color_kill;
      logic white_peak;
      logic adc_overflow;
      logic adc_underflow;
      logic field_50hz;
      logic fsc_locked;
      logic in_lock;
   } status_in_s;

   typedef struct packed {
      power_save_e power_save_select;
      logic        reference_power_save;
      logic        clockgen_power_save;
      logic        core_shutdown;
   } power_out_s;

endpackage

// File: hw/clamp_pulse_timer.sv
// Purpose: One clamp current pulse of 16, 32, 64 or 128 cycles
// Assumes: Start is a one-cycle pulse, enable is a level
// Notes:   A start during a pulse restarts it
`timescale 1ns/1ps
module clamp_pulse_timer
   import decoder_regs_pkg::*;
#(
   parameter int CNT_W = CLAMP_CNT_W
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Control
   input  wire logic       start_i,
   input  wire logic       enable_i,
   input  wire logic [1:0] len_code_i,
   // Pulse
   output logic            on_o
);

   typedef struct packed {
      logic             on;
      logic [CNT_W-1:0] cnt;
   } timer_s;

   timer_s state_r;
   timer_s state_nxt;
   logic [CNT_W-1:0] len;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      len       = CNT_W'(CLAMP_BASE_CYC) << len_code_i;
      state_nxt = state_r;
      if (!enable_i) begin
         state_nxt.on  = 1'b0;
         state_nxt.cnt = '0;
      end else if (start_i) begin
         state_nxt.on  = 1'b1;
         state_nxt.cnt = len - CNT_W'(1);
      end else if (state_r.on) begin
         if (state_r.cnt == '0) begin
            state_nxt.on = 1'b0;
         end else begin
            state_nxt.cnt = state_r.cnt - CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign on_o = state_r.on;

endmodule // clamp_pulse_timer

// File: tb/decoder_regs_props.sv
// Purpose: Port assertions for the power, status and clamp register bank
// Assumes: Zero wait-state APB slave on one clock
// Notes:   Bound to the design from the testbench top file
`timescale 1ns/1ps
module decoder_regs_props
   import decoder_regs_pkg::*;
#(
   parameter logic [7:0] REVISION_ID = 8'ha7
) (
   // Clock, reset and bus
   input wire logic              MCLK_I,
   input wire logic              RESET_I,
   input wire logic              PSEL_I,
   input wire logic              PENABLE_I,
   input wire logic              PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0]       PWDATA_I,
   input wire logic [3:0]        PSTRB_I,
   input wire logic [31:0]       PRDATA_O,
   input wire logic              PREADY_O,
   // Pins and outputs
   input wire status_in_s        STATUS_I,
   input wire logic              CLAMP_START_I,
   input wire power_out_s        POWER_O,
   input wire logic              PAD_DISABLE_O,
   input wire logic              CLK27_STOP_O,
   input wire logic              REACQUIRE_O,
   input wire logic              CORE_RESET_O,
   input wire logic              TIMING_DRV_EN_O,
   input wire logic              FINE_CLAMP_ON_O,
   input wire logic              FAST_CLAMP_ON_O,
   input wire logic              CURRENT_SRC_EN_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (RESET_I);
   logic wr_take;
   logic rd_setup;
   assign wr_take  = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & PSTRB_I[0];
   assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;

   chk_reacq_pulse: assert property (wr_take && PADDR_I == ADDR_POWER && PWDATA_I[6]
      |=> REACQUIRE_O) else $error("reacquire pulse missing");
   chk_core_reset: assert property (wr_take && PADDR_I == ADDR_POWER && PWDATA_I[7]
      |=> CORE_RESET_O ##1 !CORE_RESET_O) else $error("core reset pulse wrong");
   chk_power_fields: assert property (wr_take && PADDR_I == ADDR_POWER |=>
      {POWER_O.power_save_select, POWER_O.reference_power_save, POWER_O.clockgen_power_save}
      == $past({PWDATA_I[1:0], PWDATA_I[3], PWDATA_I[4]})) else $error("power fields wrong");
   chk_pad_follow: assert property (PAD_DISABLE_O == POWER_O.core_shutdown
      && CLK27_STOP_O == POWER_O.core_shutdown) else $error("pad or clock stop wrong");
   chk_status_bits: assert property (rd_setup && PADDR_I == ADDR_STATUS
      |=> {PRDATA_O[7:2], PRDATA_O[0]} == $past(STATUS_I)) else $error("status bits wrong");
   chk_lost_lock: assert property (rd_setup && PADDR_I == ADDR_STATUS
      && $past(!STATUS_I.in_lock) |=> PRDATA_O[1]) else $error("lost lock not kept");
   chk_rev_code: assert property (rd_setup && PADDR_I == ADDR_REVISION
      |=> PRDATA_O[7:0] == REVISION_ID) else $error("revision code wrong");
   chk_force_drv: assert property (wr_take && PADDR_I == ADDR_ANALOG && PWDATA_I[1]
      |=> TIMING_DRV_EN_O) else $error("timing drivers not forced");
   chk_fine_cause: assert property ($rose(FINE_CLAMP_ON_O)
      |-> $past(CLAMP_START_I && CURRENT_SRC_EN_O)) else $error("fine pulse without start");
   chk_fast_cause: assert property ($rose(FAST_CLAMP_ON_O)
      |-> $past(CLAMP_START_I && CURRENT_SRC_EN_O)) else $error("fast pulse without start");
   chk_clamp_off: assert property (!CURRENT_SRC_EN_O
      |=> !FINE_CLAMP_ON_O && !FAST_CLAMP_ON_O) else $error("clamp on while disabled");
endmodule // decoder_regs_props

// File: tb/host_apb_model.sv
// Purpose: Host side APB master for the register bank
// Assumes: One idle cycle before each transfer
// Notes:   Waits for ready with no limit of its own
`timescale 1ns/1ps
module host_apb_model
   import decoder_regs_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [11:0]      paddr_o,
   output logic [31:0]      pwdata_o,
   output logic [3:0]       pstrb_o
);
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 12'h000;
      pwdata_o = 32'h0;
      pstrb_o = 4'h0;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic e);
      logic [7:0] v;
      v = d;
      if (w && a == ADDR_CLAMP) v = d & 8'h3f;
      if (w && a == ADDR_ANALOG) v = (d & 8'h02) | 8'h45;
      @(posedge clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= {24'h0, v};
      pstrb_o <= 4'h1;
      @(posedge clk_i);
      penable_o <= 1'b1;
      do @(posedge clk_i); while (pready_i !== 1'b1);
      q = prdata_i[7:0];
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
   endtask
endmodule // host_apb_model

// File: tb/decoder_power_status_clamp_regs_tb.sv
// Purpose: Self-checking bench for the register bank
// Assumes: Zero wait-state bus, host model drives it
// Notes:   One task per scenario
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
   $display("unexpected %s exp %h got %h", n, e, a); end end
module decoder_power_status_clamp_regs_tb
   import decoder_regs_pkg::*;
;
   localparam logic [7:0] REV = 8'h5c; // Arbitrary value
   logic       clk, rst, psel, pen, pwr, pready, perr, pdn_n, iso, oe, cst;
   logic       pad, cstop, reacq, crst, tdrv, fine, fast, isrc, vcl;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   status_in_s  st;
   power_out_s  pw;
   int          mismatches = 0;
   int          cmp_count = 0;

   host_apb_model host (.clk_i(clk), .prdata_i(prdata), .pready_i(pready), .pslverr_i(perr),
      .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwdata),
      .pstrb_o(pstrb));
   decoder_power_status_clamp_regs #(.REVISION_ID(REV)) DUT (.MCLK_I(clk), .RESET_I(rst),
      .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
      .POWERDOWN_N_I(pdn_n), .ISO_I(iso), .OE_I(oe), .STATUS_I(st), .CLAMP_START_I(cst),
      .POWER_O(pw), .PAD_DISABLE_O(pad), .CLK27_STOP_O(cstop), .REACQUIRE_O(reacq),
      .CORE_RESET_O(crst), .TIMING_DRV_EN_O(tdrv), .FINE_CLAMP_ON_O(fine),
      .FAST_CLAMP_ON_O(fast), .CURRENT_SRC_EN_O(isrc), .VCLAMP_EN_O(vcl));

   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic e;
      host.xfer(1'b1, a, d, q, e);
      #1;
   endtask
   task automatic rdchk(input string n, input logic [11:0] a, input logic [7:0] x);
      logic [7:0] q;
      logic e;
      host.xfer(1'b0, a, 8'h00, q, e);
      `CHK(n, x, q)
   endtask
   task automatic t_reset();
      logic [7:0] q;
      logic e;
      rdchk("power", ADDR_POWER, 8'h00);
      rdchk("analog", ADDR_ANALOG, 8'h45);
      rdchk("clamp", ADDR_CLAMP, 8'h00);
      rdchk("revision", ADDR_REVISION, REV);
      host.xfer(1'b0, 12'h048, 8'h00, q, e);
      `CHK("slverr", 1'b1, e)
      `CHK("unmapped", 8'h00, q)
      $display("test reset done");
   endtask
   task automatic t_power();
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_POWER, {3'b000, c[0], c[1], 1'b0, c[1:0]});
         `CHK("select", c[1:0], pw.power_save_select)
         `CHK("ref", c[1], pw.reference_power_save)
         `CHK("cg", c[0], pw.clockgen_power_save)
      end
      $display("test power done");
   endtask
   task automatic t_shutdown();
      pdn_n <= 1'b0;
      wr(ADDR_POWER, 8'h00);
      `CHK("pin down", 1'b1, pw.core_shutdown)
      wr(ADDR_POWER, 8'h04);
      `CHK("bit up", 1'b0, pw.core_shutdown)
      wr(ADDR_POWER, 8'h24);
      `CHK("pads", 2'b11, {pad, cstop})
      pdn_n <= 1'b1;
      wr(ADDR_POWER, 8'h00);
      `CHK("pin up", 2'b00, {pad, cstop})
      $display("test shutdown done");
   endtask
   task automatic t_events();
      wr(ADDR_POWER, 8'h40);
      `CHK("reacq", 1'b1, reacq)
      @(posedge clk);
      #1 `CHK("reacq end", 1'b0, reacq)
      rdchk("self clear", ADDR_POWER, 8'h00);
      iso <= 1'b1;
      @(posedge clk);
      #1 `CHK("iso", 1'b1, reacq)
      iso <= 1'b0;
      wr(ADDR_CLAMP, 8'h30);
      wr(ADDR_POWER, 8'h80);
      `CHK("core reset", 1'b1, crst)
      @(posedge clk);
      #1 `CHK("reset end", 1'b0, crst)
      rdchk("clamp reset", ADDR_CLAMP, 8'h00);
      $display("test events done");
   endtask
   task automatic t_status();
      @(posedge clk);
      st <= 7'h2a;
      rdchk("lost", ADDR_STATUS, 8'h56);
      st <= 7'h4d;
      rdchk("sticky", ADDR_STATUS, 8'h9b);
      rdchk("cleared", ADDR_STATUS, 8'h99);
      wr(ADDR_REVISION, 8'h00);
      rdchk("rev ro", ADDR_REVISION, REV);
      $display("test status done");
   endtask
   task automatic t_timing();
      oe <= 1'b1;
      wr(ADDR_TIMING, 8'h00);
      `CHK("oe", 1'b1, tdrv)
      wr(ADDR_TIMING, 8'h01);
      `CHK("disable", 1'b0, tdrv)
      wr(ADDR_ANALOG, 8'h02);
      `CHK("force", 1'b1, tdrv)
      rdchk("analog", ADDR_ANALOG, 8'h47);
      $display("test timing done");
   endtask
   task automatic t_clamp();
      int nf;
      int nq;
      for (int c = 0; c < 5; c++) begin
         wr(ADDR_CLAMP, (c == 4) ? 8'h00 : {4'h3, ~c[1:0], c[1:0]});
         `CHK("enables", (c == 4) ? 2'b00 : 2'b11, {isrc, vcl})
         nf = 0;
         nq = 0;
         @(posedge clk);
         cst <= 1'b1;
         @(posedge clk);
         cst <= 1'b0;
         repeat (200) begin
            #1;
            if (fine === 1'b1) nf++;
            if (fast === 1'b1) nq++;
            @(posedge clk);
         end
         `CHK("fine len", (c == 4) ? 0 : 16 << c, nf)
         `CHK("fast len", (c == 4) ? 0 : 16 << (3 - c), nq)
      end
      $display("test clamp done");
   endtask
   task automatic close_out();
      $display("mismatches %0d compares %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out();
   end
   initial begin
      rst = 1'b1;
      pdn_n = 1'b1;
      iso = 1'b0;
      oe = 1'b0;
      cst = 1'b0;
      st = 7'h01;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_power();
      t_shutdown();
      t_events();
      t_status();
      t_timing();
      t_clamp();
      close_out();
   end
endmodule // decoder_power_status_clamp_regs_tb

bind decoder_power_status_clamp_regs decoder_regs_props #(.REVISION_ID(REVISION_ID)) u_props (
   .MCLK_I(MCLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
   .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .STATUS_I(STATUS_I),
   .CLAMP_START_I(CLAMP_START_I), .POWER_O(POWER_O), .PAD_DISABLE_O(PAD_DISABLE_O),
   .CLK27_STOP_O(CLK27_STOP_O), .REACQUIRE_O(REACQUIRE_O), .CORE_RESET_O(CORE_RESET_O),
   .TIMING_DRV_EN_O(TIMING_DRV_EN_O), .FINE_CLAMP_ON_O(FINE_CLAMP_ON_O),
   .FAST_CLAMP_ON_O(FAST_CLAMP_ON_O), .CURRENT_SRC_EN_O(CURRENT_SRC_EN_O));
